// ===== fbrc_pkg.sv
package fbrc_pkg;

  // ==========================================================
  // Widths
  localparam int CFG_W  = 16;
  localparam int ADDR_W = 24;
  localparam int DATA_W = 16;

  // ==========================================================
  // Configuration word layout
  localparam int CFG_READ_SELECT  = 15;
  localparam int CFG_LAT_HI       = 13;
  localparam int CFG_LAT_LO       = 11;
  localparam int CFG_STALL_POL    = 10;
  localparam int CFG_DATA_HOLD    = 9;
  localparam int CFG_STALL_TIMING = 8;
  localparam int CFG_BURST_ORDER  = 7;
  localparam int CFG_ACTIVE_EDGE  = 6;
  localparam int CFG_WRAP_SELECT  = 3;
  localparam int CFG_LEN_HI       = 2;
  localparam int CFG_LEN_LO       = 0;

  // Async reads, 7 clocks, high stall, 2-clock hold, early stall,
  // sequential, rising edge, no wrap, continuous
  localparam logic [CFG_W-1:0] CFG_RESET = 16'hBFCF;

  // ==========================================================
  // Field codes
  localparam logic [2:0] LEN_FOUR  = 3'h1;
  localparam logic [2:0] LEN_EIGHT = 3'h2;
  localparam logic [2:0] LEN_CONT  = 3'h7;
  localparam logic [2:0] LAT_MIN   = 3'h2;
  localparam logic [2:0] LAT_MAX   = 3'h7;

  // Last word offset inside an aligned 8-word group
  localparam logic [2:0] OCT_LAST  = 3'h7;
  localparam logic [2:0] OCT_FIRST = 3'h0;

  // Word count for a burst length code, zero means unbounded
  localparam logic [4:0] WORDS_FOUR  = 5'h04;
  localparam logic [4:0] WORDS_EIGHT = 5'h08;
  localparam logic [4:0] WORDS_CONT  = 5'h00;

  // ==========================================================
  // Burst engine states, Gray along idle-latency-data-stall
  typedef enum logic [1:0] {
    ST_IDLE  = 2'h0,
    ST_LAT   = 2'h1,
    ST_DATA  = 2'h3,
    ST_STALL = 2'h2
  } fbrc_state_type;

  function automatic logic [4:0] fbrc_words(input logic [2:0] lenCode);
    case (lenCode)
      LEN_FOUR:  fbrc_words = WORDS_FOUR;
      LEN_EIGHT: fbrc_words = WORDS_EIGHT;
      default:   fbrc_words = WORDS_CONT;
    endcase
  endfunction

endpackage

// ===== fbrc_sync.sv
`timescale 1ns/100ps
module fbrc_sync
  import fbrc_pkg::*;
#(
  parameter int W = 1
) (
  input  wire logic         clk,   // Destination clock
  input  wire logic         rstN,  // Async reset, active low
  input  wire logic [W-1:0] d,     // Level from another domain
  output logic      [W-1:0] q      // Synchronised level
);

  // ==========================================================
  // Two-stage synchroniser, first stage feeds only the second
  logic [W-1:0] meta_r;

  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      meta_r <= '0;
      q      <= '0;
    end else begin
      meta_r <= d;
      q      <= meta_r;
    end
  end

endmodule

// ===== fbrc_addr_gen.sv
`timescale 1ns/100ps
module fbrc_addr_gen
  import fbrc_pkg::*;
(
  input  wire logic [ADDR_W-1:0] curAddr,  // Address of current word
  input  wire logic              wrapEn,   // Wrap inside aligned group
  input  wire logic [2:0]        lenCode,  // Burst length field
  output logic      [ADDR_W-1:0] nxtAddr   // Address of following word
);

  // ==========================================================
  // Sequential order only; wrap keeps the upper bits fixed
  logic [ADDR_W-1:0] incAddr;

  always_comb begin
    incAddr = curAddr + {{(ADDR_W-1){1'b0}}, 1'b1};
    nxtAddr = incAddr;
    if (wrapEn && lenCode == LEN_FOUR) begin
      nxtAddr = {curAddr[ADDR_W-1:2], incAddr[1:0]};
    end else if (wrapEn && lenCode == LEN_EIGHT) begin
      nxtAddr = {curAddr[ADDR_W-1:3], incAddr[2:0]};
    end
  end

endmodule

// ===== fbrc_top.sv
`timescale 1ns/100ps
module fbrc_top
  import fbrc_pkg::*;
(
  input  wire logic              ref_clk,    // Core clock, 100 MHz
  input  wire logic              rst_n,      // Async reset, active low
  input  wire logic              cfgWrStb,   // Set-configuration command pulse
  input  wire logic [CFG_W-1:0]  cfgWrData,  // Word carried by that command
  input  wire logic              busClk,     // Bus clock from host
  input  wire logic              chipEnN,    // Chip enable, active low
  input  wire logic              latchEnN,   // Address latch strobe, active low
  input  wire logic              outEnN,     // Output enable, active low
  input  wire logic [ADDR_W-1:0] busAddr,    // Address pins
  input  wire logic [DATA_W-1:0] arrData,    // Array word at arrAddr
  output logic      [ADDR_W-1:0] arrAddr,    // Array read address
  output logic      [DATA_W-1:0] dataOut,    // Data pins, output value
  output logic                   dataOeN,    // Data pins enable, low drives
  output logic                   waitOut,    // Stall indicator pin
  output logic                   asyncMode,  // Active read mode is async
  output logic      [CFG_W-1:0]  cfgWord     // Last committed word
);

  // ==========================================================
  // Core reset release
  logic rstSyncN;

  fbrc_sync #(.W(1)) uRefRst (
    .clk  (ref_clk),
    .rstN (rst_n),
    .d    (1'b1),
    .q    (rstSyncN)
  );

  // ==========================================================
  // Configuration word, core side
  // Held stable between commands so the link side may sample it whole.
  logic [CFG_W-1:0] cfgHold_r;
  logic             cfgTgl_r;
  logic             invEdge_r;

  always_ff @(posedge ref_clk or negedge rstSyncN) begin
    if (!rstSyncN) begin
      cfgHold_r <= CFG_RESET;
    end else if (cfgWrStb) begin
      cfgHold_r <= cfgWrData;
    end
  end

  always_ff @(posedge ref_clk or negedge rstSyncN) begin
    if (!rstSyncN) begin
      cfgTgl_r <= 1'b0;
    end else if (cfgWrStb) begin
      cfgTgl_r <= ~cfgTgl_r;
    end
  end

  always_ff @(posedge ref_clk or negedge rstSyncN) begin
    if (!rstSyncN) begin
      cfgWord <= CFG_RESET;
    end else begin
      cfgWord <= cfgHold_r;
    end
  end

  // Quasi-static: only change the edge bit while the bus is idle
  always_ff @(posedge ref_clk or negedge rstSyncN) begin
    if (!rstSyncN) begin
      invEdge_r <= ~CFG_RESET[CFG_ACTIVE_EDGE];
    end else begin
      invEdge_r <= ~cfgHold_r[CFG_ACTIVE_EDGE];
    end
  end

  // ==========================================================
  // Link clock with selected active edge
  logic kClk;

  assign kClk = busClk ^ invEdge_r;

  logic linkRstN;

  fbrc_sync #(.W(1)) uLinkRst (
    .clk  (kClk),
    .rstN (rst_n),
    .d    (1'b1),
    .q    (linkRstN)
  );

  logic tglSync;

  fbrc_sync #(.W(1)) uTglSync (
    .clk  (kClk),
    .rstN (linkRstN),
    .d    (cfgTgl_r),
    .q    (tglSync)
  );

  // ==========================================================
  // Pending and active configuration, link side
  logic             tglSeen_r;
  logic [CFG_W-1:0] cfgPend_r;
  logic [CFG_W-1:0] cfgAct_r;
  logic             latchEvt;

  assign latchEvt = !latchEnN && !chipEnN;

  always_ff @(posedge kClk or negedge linkRstN) begin
    if (!linkRstN) begin
      tglSeen_r <= 1'b0;
      cfgPend_r <= CFG_RESET;
    end else if (tglSync != tglSeen_r) begin
      tglSeen_r <= tglSync;
      cfgPend_r <= cfgHold_r;
    end
  end

  // Applied only at an address latch, never in mid-burst
  always_ff @(posedge kClk or negedge linkRstN) begin
    if (!linkRstN) begin
      cfgAct_r <= CFG_RESET;
    end else if (latchEvt) begin
      cfgAct_r <= cfgPend_r;
    end
  end

  logic newSync;
  logic actPol;
  logic actEarly;
  logic actHold;

  assign newSync  = !cfgPend_r[CFG_READ_SELECT];
  assign actPol   = cfgAct_r[CFG_STALL_POL];
  assign actEarly = cfgAct_r[CFG_STALL_TIMING];
  assign actHold  = cfgAct_r[CFG_DATA_HOLD];

  always_ff @(posedge kClk or negedge linkRstN) begin
    if (!linkRstN) begin
      asyncMode <= CFG_RESET[CFG_READ_SELECT];
    end else begin
      asyncMode <= cfgAct_r[CFG_READ_SELECT];
    end
  end

  // ==========================================================
  // Burst address sequencing
  logic [ADDR_W-1:0] curAddr_r;
  logic [ADDR_W-1:0] nxtAddr;
  logic              wrapEn;

  // Continuous bursts ignore the wrap bit
  assign wrapEn = !cfgAct_r[CFG_WRAP_SELECT];

  fbrc_addr_gen uAddrGen (
    .curAddr (arrAddr),
    .wrapEn  (wrapEn),
    .lenCode (cfgAct_r[CFG_LEN_HI:CFG_LEN_LO]),
    .nxtAddr (nxtAddr)
  );

  // ==========================================================
  // Burst engine
  fbrc_state_type state_r;
  logic [2:0]     latCnt_r;
  logic           holdCnt_r;
  logic [4:0]     wordsLeft_r;
  logic           stallArmed_r;
  logic           wordDone;
  logic           lastWord;
  logic           crossNext;
  logic [4:0]     startWords;
  logic           startArmed;
  logic           busAddrLast_r;

  assign wordDone  = (holdCnt_r == 1'b0);
  assign lastWord  = (wordsLeft_r == 5'h01);
  assign crossNext = stallArmed_r && (curAddr_r[2:0] == OCT_LAST);

  always_comb begin
    startWords = fbrc_words(cfgPend_r[CFG_LEN_HI:CFG_LEN_LO]);
    // Only bursts that run past a group boundary can stall
    startArmed = (busAddr[2:0] != OCT_FIRST)
                 && (startWords == WORDS_CONT || cfgPend_r[CFG_WRAP_SELECT]);
  end

  always_ff @(posedge kClk or negedge linkRstN) begin
    if (!linkRstN) begin
      state_r <= ST_IDLE;
    end else if (chipEnN) begin
      state_r <= ST_IDLE;
    end else if (latchEvt) begin
      state_r <= newSync ? ST_LAT : ST_IDLE;
    end else begin
      case (state_r)
        ST_LAT: begin
          if (latCnt_r == 3'h1) begin
            state_r <= ST_DATA;
          end
        end
        ST_DATA: begin
          if (wordDone && lastWord) begin
            state_r <= ST_IDLE;
          end else if (wordDone && crossNext) begin
            state_r <= ST_STALL;
          end
        end
        ST_STALL: begin
          if (wordDone) begin
            state_r <= ST_DATA;
          end
        end
        default: begin
          state_r <= ST_IDLE;
        end
      endcase
    end
  end

  // Latency: first word launched on the L-th edge after the latch edge
  always_ff @(posedge kClk or negedge linkRstN) begin
    if (!linkRstN) begin
      latCnt_r <= LAT_MAX;
    end else if (latchEvt) begin
      latCnt_r <= cfgPend_r[CFG_LAT_HI:CFG_LAT_LO];
    end else if (state_r == ST_LAT) begin
      latCnt_r <= latCnt_r - 3'h1;
    end
  end

  always_ff @(posedge kClk or negedge linkRstN) begin
    if (!linkRstN) begin
      holdCnt_r <= 1'b0;
    end else if (state_r == ST_LAT || (state_r != ST_IDLE && wordDone)) begin
      holdCnt_r <= actHold;
    end else if (state_r != ST_IDLE) begin
      holdCnt_r <= 1'b0;
    end
  end

  // Continuous bursts keep the count at zero, so they never end here
  always_ff @(posedge kClk or negedge linkRstN) begin
    if (!linkRstN) begin
      wordsLeft_r <= WORDS_CONT;
    end else if (latchEvt) begin
      wordsLeft_r <= startWords;
    end else if (state_r == ST_DATA && wordDone && wordsLeft_r != WORDS_CONT) begin
      wordsLeft_r <= wordsLeft_r - 5'h01;
    end
  end

  always_ff @(posedge kClk or negedge linkRstN) begin
    if (!linkRstN) begin
      stallArmed_r <= 1'b0;
    end else if (latchEvt) begin
      stallArmed_r <= startArmed;
    end else if (state_r == ST_STALL) begin
      stallArmed_r <= 1'b0;
    end
  end

  // Array address runs one word ahead of the bus
  always_ff @(posedge kClk or negedge linkRstN) begin
    if (!linkRstN) begin
      arrAddr   <= '0;
      curAddr_r <= '0;
    end else if (latchEvt) begin
      arrAddr   <= busAddr;
    end else if ((state_r == ST_LAT && latCnt_r == 3'h1)
                 || (state_r == ST_STALL && wordDone)
                 || (state_r == ST_DATA && wordDone && !crossNext)) begin
      arrAddr   <= nxtAddr;
      curAddr_r <= arrAddr;
    end
  end

  // ==========================================================
  // Data pins
  always_ff @(posedge kClk or negedge linkRstN) begin
    if (!linkRstN) begin
      dataOut <= '0;
    end else if ((state_r == ST_LAT && latCnt_r == 3'h1)
                 || (state_r == ST_STALL && wordDone)
                 || (state_r == ST_DATA && wordDone && !crossNext && !lastWord)) begin
      dataOut <= arrData;
    end
  end

  // Bus released outside synchronous bursts; async data path is elsewhere
  always_ff @(posedge kClk or negedge linkRstN) begin
    if (!linkRstN) begin
      dataOeN <= 1'b1;
    end else begin
      dataOeN <= chipEnN || outEnN || latchEvt
                 || !(state_r == ST_DATA || state_r == ST_STALL
                      || (state_r == ST_LAT && latCnt_r == 3'h1))
                 || (state_r == ST_DATA && wordDone && lastWord);
    end
  end

  // ==========================================================
  // Stall indicator
  logic stallNow;

  always_comb begin
    stallNow = 1'b0;
    if (!chipEnN && !latchEvt && !asyncMode) begin
      if (actEarly) begin
        // Word before the stall carries the indicator
        stallNow = (state_r == ST_DATA && wordDone && crossNext == 1'b0
                    && stallArmed_r && curAddr_r[2:0] == 3'h6 && !lastWord
                    && wordsLeft_r != 5'h02)
                   || (state_r == ST_LAT && latCnt_r == 3'h1
                       && stallArmed_r && busAddrLast_r)
                   || (state_r == ST_DATA && !wordDone && crossNext && !lastWord);
      end else begin
        stallNow = (state_r == ST_DATA && wordDone && crossNext && !lastWord)
                   || (state_r == ST_STALL && !wordDone);
      end
    end
  end

  // First word itself ends a group: early indicator rides on it
  always_ff @(posedge kClk or negedge linkRstN) begin
    if (!linkRstN) begin
      busAddrLast_r <= 1'b0;
    end else if (latchEvt) begin
      busAddrLast_r <= (busAddr[2:0] == OCT_LAST);
    end
  end

  // Deasserted level is the inverse of the active level
  always_ff @(posedge kClk or negedge linkRstN) begin
    if (!linkRstN) begin
      waitOut <= ~CFG_RESET[CFG_STALL_POL];
    end else if (asyncMode || latchEvt) begin
      waitOut <= ~actPol;
    end else begin
      waitOut <= stallNow ? actPol : ~actPol;
    end
  end

endmodule

// ===== fbrc_top_monitor.sv
`timescale 1ns/100ps
module fbrc_top_monitor
  import fbrc_pkg::*;
(
  input wire logic              ref_clk,    // Core clock
  input wire logic              rst_n,      // Raw reset
  input wire logic              cfgWrStb,   // Config strobe
  input wire logic [CFG_W-1:0]  cfgWrData,  // Config data
  input wire logic              busClk,     // Bus clock
  input wire logic              chipEnN,    // Chip enable
  input wire logic [ADDR_W-1:0] arrAddr,    // Array address
  input wire logic [DATA_W-1:0] dataOut,    // Data pins
  input wire logic              dataOeN,    // Data enable
  input wire logic              waitOut,    // Stall indicator
  input wire logic              asyncMode,  // Async active
  input wire logic [CFG_W-1:0]  cfgWord     // Committed word
);
  // ==========================================================
  // Core domain
  reset_default_a: assert property (
    @(posedge ref_clk) disable iff (!rst_n) $rose(rst_n) |-> cfgWord == CFG_RESET)
    else $error("config word not at default after reset");
  cfg_load_a: assert property (
    @(posedge ref_clk) disable iff (!rst_n) cfgWrStb |-> ##2 cfgWord == $past(cfgWrData, 2))
    else $error("config word not loaded two cycles after strobe");
  cfg_hold_a: assert property (
    @(posedge ref_clk) disable iff (!rst_n) $changed(cfgWord) |-> $past(cfgWrStb, 2))
    else $error("config word changed without a command");
  // ==========================================================
  // Bus domain, rising edge selected throughout the bench
  oe_chip_a: assert property (
    @(posedge busClk) disable iff (!rst_n) !dataOeN |-> !$past(chipEnN))
    else $error("data driven without chip enable");
  async_idle_a: assert property (
    @(posedge busClk) disable iff (!rst_n) asyncMode && $past(asyncMode) |-> dataOeN)
    else $error("data driven in async mode");
  stall_hold_a: assert property (
    @(posedge busClk) disable iff (!rst_n)
    !cfgWord[8] && !cfgWord[9] && !dataOeN && waitOut == cfgWord[10] |-> $stable(dataOut))
    else $error("data changed during stall");
  early_wait_a: assert property (
    @(posedge busClk) disable iff (!rst_n)
    cfgWord[8] && !cfgWord[9] && !dataOeN && waitOut == cfgWord[10]
    |=> waitOut != cfgWord[10] && $stable(dataOut))
    else $error("early stall not followed by stall cycle");
  addr_step_a: assert property (
    @(posedge busClk) disable iff (!rst_n)
    cfgWord[3] && $changed(arrAddr) && !$past(dataOeN) |-> arrAddr == $past(arrAddr) + 1'b1)
    else $error("burst address not sequential");
  cover property (@(posedge busClk) !dataOeN && waitOut == cfgWord[10]);
  cover property (@(posedge busClk) $fell(dataOeN));
  cover property (@(posedge ref_clk) cfgWrStb);
endmodule

bind fbrc_top fbrc_top_monitor fbrc_top_monitor_inst (.ref_clk, .rst_n, .cfgWrStb, .cfgWrData,
  .busClk, .chipEnN, .arrAddr, .dataOut, .dataOeN, .waitOut, .asyncMode, .cfgWord);

// ===== fbrc_host_model.sv
`timescale 1ns/100ps
module fbrc_host_model
  import fbrc_pkg::*;
(
  output logic                   busClk,    // Bus clock
  output logic                   chipEnN,   // Chip enable
  output logic                   latchEnN,  // Latch strobe
  output logic                   outEnN,    // Output enable
  output logic      [ADDR_W-1:0] busAddr,   // Address pins
  output logic      [DATA_W-1:0] arrData,   // Array word
  input  wire logic [ADDR_W-1:0] arrAddr,   // Array address
  input  wire logic [DATA_W-1:0] dataOut,   // Data pins
  input  wire logic              dataOeN,   // Data enable
  input  wire logic              waitOut    // Stall indicator
);
  logic [DATA_W-1:0] dq [64];
  logic              oe [64];
  logic              wt [64];

  // Free running so config words can cross between bursts
  initial busClk = 1'b0;
  always #16 busClk = ~busClk;
  initial begin
    chipEnN  = 1'b1;
    latchEnN = 1'b1;
    outEnN   = 1'b1;
    busAddr  = '0;
  end
  // Pattern differs per address, so a wrong word shows
  assign arrData = arrAddr[DATA_W-1:0] ^ 16'hA5A5;

  // ==========================================================
  // One burst; sample k is taken just after the k-th edge past the latch
  task automatic burst(input logic [ADDR_W-1:0] a, input int n);
    @(posedge busClk);
    chipEnN  <= 1'b0;
    latchEnN <= 1'b0;
    outEnN   <= 1'b0;
    busAddr  <= a;
    @(posedge busClk);
    latchEnN <= 1'b1;
    busAddr  <= ~a;
    for (int k = 1; k <= n; k++) begin
      @(posedge busClk);
      #1;
      dq[k] = dataOut;
      oe[k] = dataOeN;
      wt[k] = waitOut;
    end
    @(posedge busClk);
    chipEnN <= 1'b1;
    outEnN  <= 1'b1;
    @(posedge busClk);
  endtask
endmodule

// ===== tb_flash_burst_read_config.sv
`timescale 1ns/100ps
`define CHK(g, e) begin nChecks++; if ((g) !== (e)) begin miscompares++; \
  $display("[ERR] %0t got %h exp %h", $time, g, e); end end
module tb_flash_burst_read_config
  import fbrc_pkg::*;
;
  logic              ref_clk, rst_n, cfgWrStb, busClk, chipEnN, latchEnN, outEnN;
  logic              dataOeN, waitOut, asyncMode;
  logic [CFG_W-1:0]  cfgWrData, cfgWord;
  logic [ADDR_W-1:0] busAddr, arrAddr;
  logic [DATA_W-1:0] arrData, dataOut;
  int                miscompares = 0;
  int                nChecks = 0;

  fbrc_top fbrc_top_inst (.ref_clk, .rst_n, .cfgWrStb, .cfgWrData, .busClk, .chipEnN,
    .latchEnN, .outEnN, .busAddr, .arrData, .arrAddr, .dataOut, .dataOeN, .waitOut,
    .asyncMode, .cfgWord);
  fbrc_host_model fbrc_host_model_inst (.busClk, .chipEnN, .latchEnN, .outEnN, .busAddr,
    .arrData, .arrAddr, .dataOut, .dataOeN, .waitOut);

  initial ref_clk = 1'b0;
  always #5 ref_clk = ~ref_clk;

  task automatic endSim();
    $display("checks %0d mismatches %0d", nChecks, miscompares);
    if (miscompares == 0 && nChecks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // Order sequential, edge rising, reserved bits zero
  function automatic logic [CFG_W-1:0] cw(input logic [2:0] lat, input logic pol, hold, tim,
                                          input logic wrap, input logic [2:0] len);
    cw = {2'b00, lat, pol, hold, tim, 2'b11, 2'b00, wrap, len};
  endfunction

  // ==========================================================
  // Write, let it cross (over four bus periods), then read back
  task automatic wrCfg(input logic [CFG_W-1:0] w);
    @(posedge ref_clk);
    cfgWrStb  <= 1'b1;
    cfgWrData <= w;
    @(posedge ref_clk);
    cfgWrStb <= 1'b0;
    repeat (20) @(posedge ref_clk);
    `CHK(cfgWord, w)
  endtask

  task automatic rd(input logic [CFG_W-1:0] w, input logic [ADDR_W-1:0] a, input int nc);
    int L, h, n, g, k, s;
    logic [ADDR_W-1:0] ad;
    logic [DATA_W-1:0] d;
    logic act, bnd, wr;
    wrCfg(w);
    L = int'(w[13:11]);
    h = w[9] ? 2 : 1;
    act = w[10];
    bnd = w[2:0] != LEN_CONT;
    wr = bnd && !w[3];
    n = w[2:0] == LEN_FOUR ? 4 : (w[2:0] == LEN_EIGHT ? 8 : nc);
    g = w[2:0] == LEN_FOUR ? 4 : 8;
    s = (a[2:0] != 3'h0 && !wr) ? 8 - int'(a[2:0]) : -1;
    fbrc_host_model_inst.burst(a, L + h * n + 2);
    `CHK(fbrc_host_model_inst.oe[L-1], 1'b1)
    k = L;
    for (int i = 0; i < n; i++) begin
      if (i == s) begin
        repeat (h) begin
          `CHK(fbrc_host_model_inst.dq[k], d)
          `CHK(fbrc_host_model_inst.oe[k], 1'b0)
          `CHK(fbrc_host_model_inst.wt[k], w[8] ? ~act : act)
          k++;
        end
      end
      ad = wr ? (a & ~ADDR_W'(g - 1)) | ((a + ADDR_W'(i)) & ADDR_W'(g - 1)) : a + ADDR_W'(i);
      d = ad[DATA_W-1:0] ^ 16'hA5A5;
      repeat (h) begin
        `CHK(fbrc_host_model_inst.dq[k], d)
        `CHK(fbrc_host_model_inst.oe[k], 1'b0)
        `CHK(fbrc_host_model_inst.wt[k], (w[8] && i + 1 == s) ? act : ~act)
        k++;
      end
    end
    `CHK(fbrc_host_model_inst.oe[k], bnd)
    $display("burst at %h done", a);
  endtask

  initial begin
    repeat (100000) @(posedge ref_clk);
    miscompares++;
    endSim();
  end

  initial begin
    rst_n = 1'b0;
    cfgWrStb = 1'b0;
    cfgWrData = '0;
    repeat (8) @(posedge ref_clk);
    rst_n <= 1'b1;
    repeat (12) @(posedge ref_clk);
    `CHK(cfgWord, CFG_RESET)
    `CHK(asyncMode, 1'b1)
    `CHK(waitOut, 1'b0)
    fbrc_host_model_inst.burst(24'h000010, 12);
    for (int k = 1; k <= 12; k++) begin
      `CHK(fbrc_host_model_inst.oe[k], 1'b1)
      `CHK(fbrc_host_model_inst.wt[k], 1'b0)
    end
    $display("async after reset done");
    // Bus runs above 30 MHz, so latency four and up only
    for (int l = 4; l <= 7; l++) begin
      rd(cw(3'(l), 1'b1, 1'b0, 1'b1, 1'b1, LEN_FOUR), 24'h000020, 0);
    end
    `CHK(asyncMode, 1'b0)
    rd(cw(3'h4, 1'b1, 1'b0, 1'b0, 1'b0, LEN_EIGHT), 24'h000045, 0);
    rd(cw(3'h5, 1'b1, 1'b1, 1'b1, 1'b0, LEN_FOUR), 24'h000036, 0);
    rd(cw(3'h4, 1'b0, 1'b0, 1'b0, 1'b1, LEN_CONT), 24'h0FFFFD, 12);
    rd(cw(3'h4, 1'b1, 1'b0, 1'b1, 1'b1, LEN_CONT), 24'h0FFFFD, 12);
    rd(cw(3'h4, 1'b1, 1'b0, 1'b0, 1'b1, LEN_EIGHT), 24'h000018, 0);
    rd(cw(3'h6, 1'b0, 1'b0, 1'b0, 1'b1, LEN_FOUR), 24'h000006, 0);
    wrCfg(CFG_RESET);
    `CHK(asyncMode, 1'b0)
    fbrc_host_model_inst.burst(24'h000008, 4);
    `CHK(asyncMode, 1'b1)
    `CHK(fbrc_host_model_inst.oe[4], 1'b1)
    $display("return to async done");
    endSim();
  end
endmodule
